// ### src/hsi_top.sv
// Purpose: I2C slave command and measurement transfer of the sensor
// Assumes: scl_i and sda_i already synchronous to clk
// Notes:   Open-drain pins, the *_o outputs are always low
`timescale 1ns/1ps
`default_nettype none
`include "hsi_params.svh"
module hsi_top
   import hsi_pkg::*;
#(
   parameter int unsigned T_CYC0    = `HSI_MS_T_RES0 * `HSI_CLK_KHZ,
   parameter int unsigned T_CYC1    = `HSI_MS_T_RES1 * `HSI_CLK_KHZ,
   parameter int unsigned T_CYC2    = `HSI_MS_T_RES2 * `HSI_CLK_KHZ,
   parameter int unsigned T_CYC3    = `HSI_MS_T_RES3 * `HSI_CLK_KHZ,
   parameter int unsigned H_CYC0    = `HSI_MS_H_RES0 * `HSI_CLK_KHZ,
   parameter int unsigned H_CYC1    = `HSI_MS_H_RES1 * `HSI_CLK_KHZ,
   parameter int unsigned H_CYC2    = `HSI_MS_H_RES2 * `HSI_CLK_KHZ,
   parameter int unsigned H_CYC3    = `HSI_MS_H_RES3 * `HSI_CLK_KHZ,
   parameter int unsigned SRST_CYC  = `HSI_MS_SRST * `HSI_CLK_KHZ - 1
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe,
   input  wire logic [15:0] adc_result,
   input  wire logic        supply_low,
   output logic [7:0]       user_settings,
   output logic             meas_busy,
   output logic             reset_busy
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   hsi_conv_if cv ();

   hsi_state_type st_q, st_d;
   hsi_kind_type  kind_q, kind_d;
   hsi_act_type   act_q, act_d;
   logic          scl_q, sda_q;
   logic [3:0]    cnt_q, cnt_d;
   logic [7:0]    sh_q, sh_d;
   logic [1:0]    idx_q, idx_d;
   logic          mack_q, mack_d;
   logic          rdusr_q, rdusr_d;
   logic          hold_q, hold_d;
   logic          srst_q, srst_d;
   logic [31:0]   srcnt_q, srcnt_d;
   logic          sdaoe_q, sdaoe_d;
   logic          scloe_q, scloe_d;
   logic [7:0]    usr_q, usr_d;
   logic          low_q, low_d;
   logic          humid_d, start_d, clear_d;
   logic          rise, fall, start_c, stop_c;
   logic [7:0]    usr_view;

   // ----------------------------------------------------------------
   // Bus conditions
   // ----------------------------------------------------------------
   assign rise    = scl_i & ~scl_q;
   assign fall    = ~scl_i & scl_q;
   assign start_c = scl_i & scl_q & sda_q & ~sda_i;
   assign stop_c  = scl_i & scl_q & ~sda_q & sda_i;

   // Reserved 5:3 read as default, bit 6 from supply monitor
   assign usr_view = (usr_q & ~`HSI_USR_RSV_MASK & 8'hBF)
                   | `HSI_USR_RSV_MASK
                   | {1'b0, low_q, 6'h00};

   function automatic logic [7:0] tx_byte(input logic       rdusr,
                                          input logic [1:0] idx,
                                          input logic [7:0] usr,
                                          input logic [15:0] res,
                                          input logic [7:0] crc);
      logic [7:0] b;
      b = crc;
      if (rdusr) begin
         b = usr;
      end else if (idx == 2'h0) begin
         b = res[15:8];
      end else if (idx == 2'h1) begin
         b = res[7:0];
      end
      return b;
   endfunction

   function automatic logic is_meas(input logic [7:0] c);
      return c == `HSI_CMD_HOLD_TH || c == `HSI_CMD_HOLD_T
          || c == `HSI_CMD_HOLD_H  || c == `HSI_CMD_POLL_TH
          || c == `HSI_CMD_POLL_T  || c == `HSI_CMD_POLL_H;
   endfunction

   // ----------------------------------------------------------------
   // Protocol engine
   // ----------------------------------------------------------------
   always_comb begin
      st_d    = st_q;
      kind_d  = kind_q;
      act_d   = act_q;
      cnt_d   = cnt_q;
      sh_d    = sh_q;
      idx_d   = idx_q;
      mack_d  = mack_q;
      rdusr_d = rdusr_q;
      hold_d  = hold_q;
      srst_d  = srst_q;
      sdaoe_d = sdaoe_q;
      scloe_d = scloe_q;
      usr_d   = usr_q;
      low_d   = low_q;
      humid_d = 1'b0;
      start_d = 1'b0;
      clear_d = 1'b0;
      srcnt_d = (srcnt_q != 32'h0) ? srcnt_q - 32'h1 : srcnt_q;
      if (cv.done) begin
         low_d = supply_low;
      end
      if (stop_c) begin
         st_d    = ST_IDLE;
         sdaoe_d = 1'b0;
      end else if (start_c && st_q != ST_HOLD) begin
         st_d    = ST_RX;
         kind_d  = K_ADDR;
         cnt_d   = 4'h0;
         sdaoe_d = 1'b0;
      end else begin
         case (st_q)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (rise) begin
                  sh_d  = {sh_q[6:0], sda_i};
                  cnt_d = cnt_q + 4'h1;
               end
               if (fall && cnt_q == 4'h8) begin
                  st_d    = ST_RACK;
                  act_d   = A_END;
                  sdaoe_d = 1'b1;
                  case (kind_q)
                     K_ADDR: begin
                        if (sh_q[7:1] != `HSI_DEV_ADDR
                            || srcnt_q != 32'h0) begin
                           st_d    = ST_IDLE;
                           sdaoe_d = 1'b0;
                        end else if (!sh_q[0]) begin
                           kind_d = K_CMD;
                           act_d  = A_RX;
                        end else if (rdusr_q || cv.ready) begin
                           act_d   = A_TX;
                           idx_d   = 2'h0;
                           clear_d = ~rdusr_q;
                        end else if (cv.busy && hold_q) begin
                           act_d = A_HOLD;
                        end else begin
                           sdaoe_d = 1'b0;
                        end
                     end
                     K_CMD: begin
                        rdusr_d = 1'b0;
                        if (is_meas(sh_q)) begin
                           start_d = 1'b1;
                           humid_d = ~sh_q[1];
                           hold_d  = ~sh_q[4];
                           if (!usr_q[`HSI_USR_NORELOAD]) begin
                              usr_d[`HSI_USR_RES_HI] = 1'b0;
                              usr_d[`HSI_USR_RES_LO] = 1'b0;
                           end
                        end else if (sh_q == `HSI_CMD_RD_USER) begin
                           rdusr_d = 1'b1;
                        end else if (sh_q == `HSI_CMD_WR_USER) begin
                           kind_d = K_WDATA;
                           act_d  = A_RX;
                        end else if (sh_q == `HSI_CMD_SRST) begin
                           srst_d = 1'b1;
                        end else begin
                           sdaoe_d = 1'b0;
                        end
                     end
                     default: begin
                        usr_d[`HSI_USR_RES_HI]   = sh_q[`HSI_USR_RES_HI];
                        usr_d[`HSI_USR_HEATER]   = sh_q[`HSI_USR_HEATER];
                        usr_d[`HSI_USR_NORELOAD] = sh_q[`HSI_USR_NORELOAD];
                        usr_d[`HSI_USR_RES_LO]   = sh_q[`HSI_USR_RES_LO];
                     end
                  endcase
               end
            end
            ST_RACK: begin
               if (fall) begin
                  sdaoe_d = 1'b0;
                  cnt_d   = 4'h0;
                  case (act_q)
                     A_RX: begin
                        st_d = ST_RX;
                     end
                     A_TX: begin
                        sh_d    = tx_byte(rdusr_q, 2'h0, usr_view,
                                          cv.result, cv.crc);
                        sdaoe_d = ~sh_d[7];
                        st_d    = ST_TX;
                     end
                     A_HOLD: begin
                        scloe_d = 1'b1;
                        st_d    = ST_HOLD;
                     end
                     default: begin
                        st_d = ST_IDLE;
                        if (srst_q) begin
                           srst_d  = 1'b0;
                           clear_d = 1'b1;
                           srcnt_d = 32'(SRST_CYC);
                           usr_d   = (`HSI_USR_RESET
                                   & ~(8'h01 << `HSI_USR_HEATER))
                                   | (usr_q & (8'h01 << `HSI_USR_HEATER));
                           rdusr_d = 1'b0;
                        end
                     end
                  endcase
               end
            end
            ST_HOLD: begin
               scloe_d = 1'b1;
               if (cv.ready) begin
                  sh_d    = tx_byte(1'b0, 2'h0, usr_view,
                                    cv.result, cv.crc);
                  sdaoe_d = ~sh_d[7];
                  idx_d   = 2'h0;
                  clear_d = 1'b1;
                  st_d    = ST_REL;
               end else if (!cv.busy) begin
                  scloe_d = 1'b0;
                  st_d    = ST_IDLE;
               end
            end
            ST_REL: begin
               scloe_d = 1'b0;
               cnt_d   = 4'h0;
               st_d    = ST_TX;
            end
            ST_TX: begin
               if (rise) begin
                  cnt_d = cnt_q + 4'h1;
               end
               if (fall) begin
                  if (cnt_q == 4'h8) begin
                     sdaoe_d = 1'b0;
                     st_d    = ST_TACK;
                  end else begin
                     sh_d    = {sh_q[6:0], 1'b0};
                     sdaoe_d = ~sh_q[6];
                  end
               end
            end
            ST_TACK: begin
               if (rise) begin
                  mack_d = ~sda_i;
               end
               if (fall) begin
                  cnt_d = 4'h0;
                  if (mack_q && !rdusr_q && idx_q != 2'h2) begin
                     idx_d   = idx_q + 2'h1;
                     sh_d    = tx_byte(1'b0, idx_q + 2'h1, usr_view,
                                       cv.result, cv.crc);
                     sdaoe_d = ~sh_d[7];
                     st_d    = ST_TX;
                  end else begin
                     st_d = ST_IDLE;
                  end
               end
            end
            default: begin
               st_d = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q    <= ST_IDLE;
         kind_q  <= K_ADDR;
         act_q   <= A_END;
         scl_q   <= 1'b1;
         sda_q   <= 1'b1;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         idx_q   <= 2'h0;
         mack_q  <= 1'b0;
         rdusr_q <= 1'b0;
         hold_q  <= 1'b0;
         srst_q  <= 1'b0;
         srcnt_q <= 32'h0;
         sdaoe_q <= 1'b0;
         scloe_q <= 1'b0;
         usr_q   <= `HSI_USR_RESET;
         low_q   <= 1'b0;
      end else begin
         st_q    <= st_d;
         kind_q  <= kind_d;
         act_q   <= act_d;
         scl_q   <= scl_i;
         sda_q   <= sda_i;
         cnt_q   <= cnt_d;
         sh_q    <= sh_d;
         idx_q   <= idx_d;
         mack_q  <= mack_d;
         rdusr_q <= rdusr_d;
         hold_q  <= hold_d;
         srst_q  <= srst_d;
         srcnt_q <= srcnt_d;
         sdaoe_q <= sdaoe_d;
         scloe_q <= scloe_d;
         usr_q   <= usr_d;
         low_q   <= low_d;
      end
   end

   // ----------------------------------------------------------------
   // Conversion engine
   // ----------------------------------------------------------------
   assign cv.start = start_d;
   assign cv.humid = humid_d;
   assign cv.res   = {usr_d[`HSI_USR_RES_HI], usr_d[`HSI_USR_RES_LO]};
   assign cv.clear = clear_d;

   hsi_conv #(
      .T_CYC0 (T_CYC0),
      .T_CYC1 (T_CYC1),
      .T_CYC2 (T_CYC2),
      .T_CYC3 (T_CYC3),
      .H_CYC0 (H_CYC0),
      .H_CYC1 (H_CYC1),
      .H_CYC2 (H_CYC2),
      .H_CYC3 (H_CYC3)
   ) u_conv (
      .clk        (clk),
      .rst_n      (rst_n),
      .adc_result (adc_result),
      .cv         (cv.eng)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign scl_o         = 1'b0;
   assign sda_o         = 1'b0;
   assign scl_oe        = scloe_q;
   assign sda_oe        = sdaoe_q;
   assign user_settings = usr_view;
   assign meas_busy     = cv.busy;
   assign reset_busy    = (srcnt_q != 32'h0);

endmodule
`default_nettype wire

// ### src/hsi_params.svh
// Purpose: Constants of the humidity sensor I2C slave
// Assumes: 200 MHz system clock
// Notes:   Times in ms, cycle counts derived from the clock rate
`ifndef HSI_PARAMS_SVH
`define HSI_PARAMS_SVH

// ----------------------------------------------------------------
// Bus address and commands
// ----------------------------------------------------------------
`define HSI_DEV_ADDR     7'h40
`define HSI_CMD_HOLD_TH  8'hE1
`define HSI_CMD_HOLD_T   8'hE3
`define HSI_CMD_HOLD_H   8'hE5
`define HSI_CMD_POLL_TH  8'hF1
`define HSI_CMD_POLL_T   8'hF3
`define HSI_CMD_POLL_H   8'hF5
`define HSI_CMD_WR_USER  8'hE6
`define HSI_CMD_RD_USER  8'hE7
`define HSI_CMD_SRST     8'hFE

// ----------------------------------------------------------------
// User settings fields
// ----------------------------------------------------------------
`define HSI_USR_RES_HI   7
`define HSI_USR_LOWSUP   6
`define HSI_USR_HEATER   2
`define HSI_USR_NORELOAD 1
`define HSI_USR_RES_LO   0
`define HSI_USR_RSV_MASK 8'h38
`define HSI_USR_RESET    8'h3A

// ----------------------------------------------------------------
// Timing and checksum
// ----------------------------------------------------------------
`define HSI_CLK_KHZ      200000
`define HSI_MS_T_RES0    16
`define HSI_MS_T_RES1    8
`define HSI_MS_T_RES2    8
`define HSI_MS_T_RES3    4
`define HSI_MS_H_RES0    18
`define HSI_MS_H_RES1    4
`define HSI_MS_H_RES2    10
`define HSI_MS_H_RES3    10
`define HSI_MS_SRST      15
`define HSI_CRC_POLY     8'h31
`define HSI_CRC_INIT     8'h00

`endif

// ### src/hsi_pkg.sv
// Purpose: Types of the humidity sensor I2C slave
// Assumes: Nothing
// Notes:   Constants live in hsi_params.svh
package hsi_pkg;

   typedef enum logic [2:0] {
      ST_IDLE, ST_RX, ST_RACK, ST_HOLD, ST_REL, ST_TX, ST_TACK
   } hsi_state_type;

   typedef enum logic [1:0] {
      K_ADDR, K_CMD, K_WDATA
   } hsi_kind_type;

   typedef enum logic [1:0] {
      A_RX, A_TX, A_HOLD, A_END
   } hsi_act_type;

endpackage

// ### src/hsi_conv_if.sv
// Purpose: Link between bus logic and conversion engine
// Assumes: Single clock domain
// Notes:   start and clear are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
interface hsi_conv_if;
   logic        start;
   logic        humid;
   logic [1:0]  res;
   logic        clear;
   logic        busy;
   logic        ready;
   logic        done;
   logic [15:0] result;
   logic [7:0]  crc;

   modport ctl (output start, humid, res, clear,
                input  busy, ready, done, result, crc);
   modport eng (input  start, humid, res, clear,
                output busy, ready, done, result, crc);
endinterface
`default_nettype wire

// ### src/hsi_conv.sv
// Purpose: Conversion timer, result framing and checksum
// Assumes: adc_result is valid at end of conversion
// Notes:   clear aborts a running conversion and drops ready, except in its completion cycle
`timescale 1ns/1ps
`default_nettype none
`include "hsi_params.svh"
module hsi_conv
   import hsi_pkg::*;
#(
   parameter int unsigned T_CYC0 = 3200000,
   parameter int unsigned T_CYC1 = 1600000,
   parameter int unsigned T_CYC2 = 1600000,
   parameter int unsigned T_CYC3 = 800000,
   parameter int unsigned H_CYC0 = 3600000,
   parameter int unsigned H_CYC1 = 800000,
   parameter int unsigned H_CYC2 = 2000000,
   parameter int unsigned H_CYC3 = 2000000
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] adc_result,
   hsi_conv_if.eng          cv
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] dur(input logic h, input logic [1:0] r);
      logic [31:0] v;
      v = 32'(T_CYC0);
      case ({h, r})
         3'h0:    v = 32'(T_CYC0);
         3'h1:    v = 32'(T_CYC1);
         3'h2:    v = 32'(T_CYC2);
         3'h3:    v = 32'(T_CYC3);
         3'h4:    v = 32'(H_CYC0);
         3'h5:    v = 32'(H_CYC1);
         3'h6:    v = 32'(H_CYC2);
         default: v = 32'(H_CYC3);
      endcase
      return v;
   endfunction

   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = `HSI_CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (c[7] ^ d[i]) begin
            c = {c[6:0], 1'b0} ^ `HSI_CRC_POLY;
         end else begin
            c = {c[6:0], 1'b0};
         end
      end
      return c;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic        busy_q, busy_d;
   logic        ready_q, ready_d;
   logic        done_q, done_d;
   logic        humid_q, humid_d;
   logic [31:0] cnt_q, cnt_d;
   logic [15:0] res_q, res_d;
   logic [7:0]  crc_q, crc_d;
   logic [15:0] framed;

   // Measurement type in bit 1, bit 0 unassigned
   assign framed = {adc_result[15:2], humid_q, 1'b0};

   always_comb begin
      busy_d  = busy_q;
      ready_d = ready_q;
      humid_d = humid_q;
      cnt_d   = cnt_q;
      res_d   = res_q;
      crc_d   = crc_q;
      done_d  = 1'b0;
      if (cv.clear) begin
         ready_d = 1'b0;
         busy_d  = 1'b0;
      end
      if (cv.start) begin
         busy_d  = 1'b1;
         ready_d = 1'b0;
         humid_d = cv.humid;
         cnt_d   = dur(cv.humid, cv.res);
      end else if (busy_q) begin
         // Completion wins over a same-cycle clear
         if (cnt_q <= 32'h1) begin
            busy_d  = 1'b0;
            ready_d = 1'b1;
            done_d  = 1'b1;
            res_d   = framed;
            crc_d   = crc8(framed);
         end else begin
            cnt_d = cnt_q - 32'h1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q  <= 1'b0;
         ready_q <= 1'b0;
         done_q  <= 1'b0;
         humid_q <= 1'b0;
         cnt_q   <= 32'h0;
         res_q   <= 16'h0;
         crc_q   <= 8'h0;
      end else begin
         busy_q  <= busy_d;
         ready_q <= ready_d;
         done_q  <= done_d;
         humid_q <= humid_d;
         cnt_q   <= cnt_d;
         res_q   <= res_d;
         crc_q   <= crc_d;
      end
   end

   assign cv.busy   = busy_q;
   assign cv.ready  = ready_q;
   assign cv.done   = done_q;
   assign cv.result = res_q;
   assign cv.crc    = crc_q;

endmodule
`default_nettype wire

// ### test/hsi_top_props.sv
// Purpose: Port checks of the sensor bus slave
// Assumes: Bench resolves the open-drain wires
// Notes:   Bound into hsi_top
`timescale 1ns/1ps
`default_nettype none
module hsi_top_props #(
   parameter int unsigned SRST_CYC = 100
) (
   input wire logic       clk,
   input wire logic       rst_n,
   input wire logic       scl_i,
   input wire logic       scl_oe,
   input wire logic       sda_oe,
   input wire logic [7:0] user_settings,
   input wire logic       meas_busy,
   input wire logic       reset_busy
);
   logic [31:0] cnt_q;
   logic [31:0] cnt_d;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   always_comb cnt_d = reset_busy ? cnt_q + 32'h1 : 32'h0;
   always_ff @(posedge clk or negedge rst_n)
      if (!rst_n) cnt_q <= 32'h0;
      else cnt_q <= cnt_d;
   property p_rst;
      $rose(rst_n) |-> !scl_oe && !sda_oe && user_settings == 8'h3A;
   endproperty
   a_rst: assert property (p_rst) else $error("reset state");
   property p_hold;
      scl_oe |-> meas_busy || $past(meas_busy) || $past(meas_busy, 2);
   endproperty
   a_hold: assert property (p_hold) else $error("stray stretch");
   property p_free; $fell(meas_busy) |-> ##[0:4] !scl_oe; endproperty
   a_free: assert property (p_free) else $error("no release");
   property p_sda; $changed(sda_oe) |-> !scl_i; endproperty
   a_sda: assert property (p_sda) else $error("sda moved");
   property p_ack;
      $rose(sda_oe) && !scl_oe |->
         !$past(scl_i) && ($past(scl_i, 2) || $past(scl_i, 3));
   endproperty
   a_ack: assert property (p_ack) else $error("late drive");
   property p_excl; reset_busy |-> !meas_busy; endproperty
   a_excl: assert property (p_excl) else $error("busy in reset");
   property p_srst; cnt_q <= SRST_CYC; endproperty
   a_srst: assert property (p_srst) else $error("reset too long");
   property p_dflt;
      $rose(reset_busy) |-> ##[0:3] (user_settings & 8'hBB) == 8'h3A;
   endproperty
   a_dflt: assert property (p_dflt) else $error("no defaults");
   property p_low;
      $changed(user_settings[6]) |->
         $past(meas_busy) || $past(meas_busy, 2) || $past(reset_busy);
   endproperty
   a_low: assert property (p_low) else $error("bit 6 moved");
   c_hold: cover property (scl_oe [*3]);
   c_srst: cover property ($rose(reset_busy));
   c_done: cover property ($fell(meas_busy) ##1 !scl_oe);
endmodule
bind hsi_top hsi_top_props #(.SRST_CYC(SRST_CYC)) u_props (.clk(clk),
   .rst_n(rst_n), .scl_i(scl_i), .scl_oe(scl_oe), .sda_oe(sda_oe),
   .user_settings(user_settings), .meas_busy(meas_busy),
   .reset_busy(reset_busy));
`default_nettype wire

// ### test/hsi_master.sv
// Purpose: Bus master model for the sensor slave
// Assumes: Pull-up wires, a high pull holds the line low
// Notes:   Clock stretch wait is bounded
`timescale 1ns/1ps
`default_nettype none
module hsi_master (
   input  wire logic clk,
   input  wire logic scl,
   input  wire logic sda,
   output var logic  scl_pull,
   output var logic  sda_pull
);
   initial scl_pull = 1'b0;
   initial sda_pull = 1'b0;
   task automatic ln(input logic s, input logic c);
      sda_pull <= s;
      scl_pull <= c;
      repeat (4) @(posedge clk);
   endtask
   task automatic start();
      ln(1'b0, 1'b1);
      ln(1'b0, 1'b0);
      ln(1'b1, 1'b0);
      ln(1'b1, 1'b1);
   endtask
   task automatic stop();
      ln(1'b1, 1'b1);
      ln(1'b1, 1'b0);
      ln(1'b0, 1'b0);
   endtask
   task automatic bitx(input logic b, output logic r);
      ln(~b, 1'b1);
      scl_pull <= 1'b0;
      for (int n = 0; scl !== 1'b1 && n < 9000; n++)
         @(posedge clk);
      repeat (3) @(posedge clk);
      r = sda;
      ln(~b, 1'b1);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic [7:0] a);
      for (int i = 7; i >= 0; i--)
         bitx(b[i], a[0]);
      a[7:1] = 7'h00;
      bitx(1'b1, a[0]);
   endtask
   task automatic rbyte(input logic k, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(1'b1, b[i]);
      bitx(~k, r);
   endtask
endmodule
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench of the sensor bus slave
// Assumes: Master model drives the bus
// Notes:   Shortened conversion and reset counts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        supply_low = 1'b0;
   logic [15:0] adc_result = 16'h0000;
   logic        scl_pull, sda_pull, scl_o, scl_oe, sda_o, sda_oe;
   logic        meas_busy, reset_busy;
   logic [7:0]  user_settings, got;
   logic [7:0]  exq[$];
   logic [7:0]  cl[6] = '{8'hE3, 8'hF1, 8'hF5, 8'hE1, 8'hE5, 8'hF3};
   int          failures = 0;
   int          comparisons = 0;
   event        ev;
   wire logic   scl = ~scl_pull & (scl_oe ? scl_o : 1'b1);
   wire logic   sda = ~sda_pull & (sda_oe ? sda_o : 1'b1);
   always #2.5 clk = ~clk;
   hsi_top #(.T_CYC0(400), .T_CYC1(200), .T_CYC2(200), .T_CYC3(100),
      .H_CYC0(480), .H_CYC1(100), .H_CYC2(250), .H_CYC3(250),
      .SRST_CYC(400)) dut (.clk(clk),
      .rst_n(rst_n), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
      .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .adc_result(adc_result),
      .supply_low(supply_low), .user_settings(user_settings),
      .meas_busy(meas_busy), .reset_busy(reset_busy));
   hsi_master m (.clk(clk), .scl(scl), .sda(sda), .scl_pull(scl_pull),
      .sda_pull(sda_pull));
   task automatic cmp(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("Error at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   always @(ev) cmp(got, exq.pop_front());
   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 15; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h31 : 8'h00);
      return c;
   endfunction
   task automatic io(input logic rx, input logic [7:0] v, input logic k);
      exq.push_back(rx ? v : {7'h00, k});
      if (rx) m.rbyte(k, got);
      else m.wbyte(v, got);
      ->ev;
   endtask
   task automatic idle();
      for (int n = 0; (meas_busy | reset_busy) !== 1'b0 && n < 9000; n++)
         @(posedge clk);
      if ((meas_busy | reset_busy) !== 1'b0) begin
         failures++;
         $display("Error at %0t: busy wait expired", $time);
      end
   endtask
   task automatic cmd(input logic [7:0] c, input logic k);
      m.start();
      io(1'b0, 8'h80, 1'b0);
      io(1'b0, c, k);
   endtask
   task automatic rdu(input logic [7:0] e);
      cmd(8'hE7, 1'b0);
      m.start();
      io(1'b0, 8'h81, 1'b0);
      io(1'b1, e, 1'b0);
      m.stop();
   endtask
   task automatic wru(input logic [7:0] v);
      cmd(8'hE6, 1'b0);
      io(1'b0, v, 1'b0);
      m.stop();
   endtask
   task automatic meas(input logic [7:0] c, input logic full);
      logic [15:0] r;
      logic [7:0]  lo;
      adc_result <= 16'($urandom);
      @(posedge clk);
      r = {adc_result[15:2], c[1:0] != 2'b11, 1'b0};
      cmd(c, 1'b0);
      m.start();
      if (c[4]) begin
         io(1'b0, 8'h81, 1'b1);
         idle();
         m.start();
      end
      io(1'b0, 8'h81, 1'b0);
      io(1'b1, r[15:8], 1'b1);
      io(1'b1, r[7:0], full);
      lo = got;
      if (full) io(1'b1, crc8(r), 1'b0);
      m.stop();
      exq.push_back({adc_result[7:2], 2'b00});
      got = lo & 8'hFC;
      ->ev;
   endtask
   initial begin
      void'($urandom(32'h23D9548B));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      exq.push_back(8'h3A);
      got = user_settings;
      ->ev;
      rdu(8'h3A);
      wru(8'hBF);
      rdu(8'hBF);
      cmd(8'hFE, 1'b0);
      m.stop();
      m.start();
      io(1'b0, 8'h80, 1'b1);
      m.stop();
      idle();
      rdu(8'h3E);
      m.start();
      io(1'b0, 8'h82, 1'b1);
      cmd(8'hAA, 1'b1);
      m.stop();
      wru(8'h3D);
      meas(8'hF3, 1'b1);
      rdu(8'h3C);
      supply_low <= 1'b1;
      foreach (cl[i]) meas(cl[i], i[0]);
      rdu(8'h7C);
      wru(8'hFF);
      meas(8'hF5, 1'b1);
      rdu(8'hFF);
      repeat (4) @(posedge clk);
      complete_run();
   end
   initial begin
      #300000;
      failures++;
      complete_run();
   end
endmodule
`default_nettype wire
